// ### inc_or_move_branch_pkg.sv
package inc_or_move_branch_pkg;

	// ************************************************************
	// Widths.
	// ************************************************************
	localparam int ADR_W = 8;
	localparam int DATA_W = 32;
	localparam int SEL_W = 4;
	localparam int BYTE_W = 8;
	localparam int PC_W = 11;
	localparam int FILE_DEPTH = 32;
	localparam int F_W = 5;
	localparam int K_W = 9;
	localparam int OP_W = 4;

	// ************************************************************
	// Register offsets (byte addresses).
	// ************************************************************
	localparam logic [7:0] EXEC_OFS = 8'h00;
	localparam logic [7:0] ACC_OFS = 8'h04;
	localparam logic [7:0] STATUS_OFS = 8'h08;
	localparam logic [7:0] PC_OFS = 8'h0c;
	localparam logic [7:0] STATE_OFS = 8'h10;
	localparam logic [7:0] FILE_BASE = 8'h80;
	localparam int FILE_SEL_BIT = 7;
	localparam int FILE_IDX_LSB = 2;

	// ************************************************************
	// Field positions.
	// ************************************************************
	localparam int OP_LSB = 0;
	localparam int DEST_BIT = 4;
	localparam int F_LSB = 8;
	localparam int K_LSB = 16;
	localparam int STATUS_Z_BIT = 2;
	localparam int STATUS_PAGE_LSB = 5;
	localparam int PAGE_W = 2;

	// ************************************************************
	// Reset values.
	// ************************************************************
	localparam logic [31:0] EXEC_RST = 32'h0000_0000;
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [10:0] PC_RST = 11'h000;
	localparam logic [7:0] FILE_RST = 8'h00;

	// ************************************************************
	// Operation codes; codes 8 to 15 execute as no-operation.
	// ************************************************************
	localparam logic [3:0] no_operation_op = 4'h0;
	localparam logic [3:0] increment_register_op = 4'h1;
	localparam logic [3:0] increment_skip_zero_op = 4'h2;
	localparam logic [3:0] branch_absolute_op = 4'h3;
	localparam logic [3:0] or_immediate_op = 4'h4;
	localparam logic [3:0] or_accumulator_register_op = 4'h5;
	localparam logic [3:0] store_accumulator_op = 4'h6;
	localparam logic [3:0] move_register_op = 4'h7;

	typedef enum logic {
		ST_RUN,
		ST_FLUSH
	} exec_state_e;

endpackage : inc_or_move_branch_pkg

// ### lane_merge.sv
`timescale 1ns/1ps

// ************************************************************
// Byte-lane write merge.
// ************************************************************
module lane_merge
	import inc_or_move_branch_pkg::*;
#(
	parameter int W = 8
) (
	// Old value and bus data.
	input wire logic [W-1:0] old_i,
	input wire logic [W-1:0] new_i,
	input wire logic [SEL_W-1:0] sel_i,
	// Merged value.
	output logic [W-1:0] merged_o
);

	always_comb begin
		for (int b = 0; b < W; b++) begin
			merged_o[b] = sel_i[b / BYTE_W] ? new_i[b] : old_i[b];
		end
	end

endmodule : lane_merge

// ### exec_alu.sv
`timescale 1ns/1ps

// ************************************************************
// Result and write enables of one instruction.
// ************************************************************
module exec_alu
	import inc_or_move_branch_pkg::*;
(
	// Operation and operands.
	input wire logic [OP_W-1:0] op_i,
	input wire logic dest_i,
	input wire logic [7:0] acc_i,
	input wire logic [7:0] freg_i,
	input wire logic [7:0] k8_i,
	// Result and its routing.
	output logic [7:0] result_o,
	output logic acc_we_o,
	output logic file_we_o,
	output logic z_we_o,
	output logic skip_o
);

	always_comb begin
		result_o = 8'h00;
		acc_we_o = 1'b0;
		file_we_o = 1'b0;
		z_we_o = 1'b0;
		skip_o = 1'b0;
		case (op_i)
			increment_register_op: begin
				result_o = 8'(freg_i + 8'h01);
				acc_we_o = ~dest_i;
				file_we_o = dest_i;
				z_we_o = 1'b1;
			end
			increment_skip_zero_op: begin
				result_o = 8'(freg_i + 8'h01);
				acc_we_o = ~dest_i;
				file_we_o = dest_i;
				skip_o = (result_o == 8'h00);
			end
			or_immediate_op: begin
				result_o = acc_i | k8_i;
				acc_we_o = 1'b1;
				z_we_o = 1'b1;
			end
			or_accumulator_register_op: begin
				result_o = acc_i | freg_i;
				acc_we_o = ~dest_i;
				file_we_o = dest_i;
				z_we_o = 1'b1;
			end
			store_accumulator_op: begin
				result_o = acc_i;
				file_we_o = 1'b1;
			end
			move_register_op: begin
				result_o = freg_i;
				acc_we_o = ~dest_i;
				file_we_o = dest_i;
				z_we_o = 1'b1;
			end
			default: begin
				result_o = 8'h00;
			end
		endcase
	end

endmodule : exec_alu

// ### inc_or_move_branch_exec.sv
`timescale 1ns/1ps

module inc_or_move_branch_exec
	import inc_or_move_branch_pkg::*;
(
	// Clock, reset and enable.
	input wire logic sys_clk_i,
	input wire logic srst_i,
	input wire logic ce_i,
	// Wishbone slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [SEL_W-1:0] wb_sel_i,
	input wire logic [DATA_W-1:0] wb_dat_i,
	output logic [DATA_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	// Core state.
	output logic [PC_W-1:0] pc_o,
	output logic busy_o,
	output logic skip_o
);
	default clocking dflt_cb @(posedge sys_clk_i); endclocking
	default disable iff (srst_i);

	// ************************************************************
	// State.
	// ************************************************************
	logic [DATA_W-1:0] exec_ff;
	logic [7:0] acc_ff;
	logic [7:0] status_ff;
	logic [PC_W-1:0] pc_ff;
	logic [7:0] file_mem [FILE_DEPTH];
	logic skip_ff;
	logic busy_ff;
	logic ack_ff;
	logic [DATA_W-1:0] dat_ff;
	exec_state_e state_ff;
	exec_state_e nxt_state;

	// ************************************************************
	// Bus decode.
	// ************************************************************
	logic req;
	logic exec_hit;
	logic file_hit;
	logic stall;
	logic take;
	logic bus_wr;
	logic issue;
	logic [F_W-1:0] bus_idx;
	logic [DATA_W-1:0] rd_mux;

	assign req = wb_cyc_i & wb_stb_i & ~ack_ff & ce_i;
	assign exec_hit = (wb_adr_i == EXEC_OFS);
	assign file_hit = wb_adr_i[FILE_SEL_BIT] == FILE_BASE[FILE_SEL_BIT]
		&& wb_adr_i[1:0] == 2'h0;
	assign bus_idx = wb_adr_i[FILE_IDX_LSB +: F_W];
	assign stall = wb_we_i & exec_hit & (state_ff == ST_FLUSH);
	assign take = req & ~stall;
	assign bus_wr = take & wb_we_i;
	assign issue = bus_wr & exec_hit;

	// ************************************************************
	// Instruction decode and execution.
	// ************************************************************
	logic [DATA_W-1:0] exec_word;
	logic [OP_W-1:0] op;
	logic dest;
	logic [F_W-1:0] f_idx;
	logic [K_W-1:0] k9;
	logic [7:0] file_rd;
	logic [7:0] alu_res;
	logic acc_we;
	logic file_we;
	logic z_we;
	logic skip_req;
	logic run;
	logic is_branch;
	logic [PC_W-1:0] branch_tgt;
	lane_merge #(.W(DATA_W)) u_exec_merge (
		.old_i(exec_ff),
		.new_i(wb_dat_i),
		.sel_i(wb_sel_i),
		.merged_o(exec_word)
	);
	assign f_idx = exec_word[F_LSB +: F_W];
	assign dest = exec_word[DEST_BIT];
	assign op = exec_word[OP_LSB +: OP_W];
	assign k9 = exec_word[K_LSB +: K_W];
	assign file_rd = file_mem[f_idx];
	assign run = issue & ~skip_ff;
	assign is_branch = (op == branch_absolute_op);
	assign branch_tgt = {status_ff[STATUS_PAGE_LSB +: PAGE_W], k9};
	exec_alu u_alu (
		.op_i(op),
		.dest_i(dest),
		.acc_i(acc_ff),
		.freg_i(file_rd),
		.k8_i(k9[7:0]),
		.result_o(alu_res),
		.acc_we_o(acc_we),
		.file_we_o(file_we),
		.z_we_o(z_we),
		.skip_o(skip_req)
	);

	// ************************************************************
	// Bus write merges.
	// ************************************************************
	// One merge serves the byte-wide registers, as one request is taken.
	logic [7:0] byte_old;
	logic [7:0] byte_wr;
	logic [PC_W-1:0] pc_wr;
	assign byte_old = (wb_adr_i == ACC_OFS) ? acc_ff
		: (wb_adr_i == STATUS_OFS) ? status_ff : file_mem[bus_idx];
	lane_merge #(.W(8)) u_byte_merge (
		.old_i(byte_old),
		.new_i(wb_dat_i[7:0]),
		.sel_i(wb_sel_i),
		.merged_o(byte_wr)
	);
	lane_merge #(.W(PC_W)) u_pc_merge (
		.old_i(pc_ff),
		.new_i(wb_dat_i[PC_W-1:0]),
		.sel_i(wb_sel_i),
		.merged_o(pc_wr)
	);

	// ************************************************************
	// Architectural registers.
	// ************************************************************
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			acc_ff <= ACC_RST;
		end else if (run & acc_we) begin
			acc_ff <= alu_res;
		end else if (bus_wr & (wb_adr_i == ACC_OFS)) begin
			acc_ff <= byte_wr;
		end
	end
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			status_ff <= STATUS_RST;
		end else if (run & z_we) begin
			status_ff[STATUS_Z_BIT] <= (alu_res == 8'h00);
		end else if (bus_wr & (wb_adr_i == STATUS_OFS)) begin
			status_ff <= byte_wr;
		end
	end
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			pc_ff <= PC_RST;
		end else if (run & is_branch) begin
			pc_ff <= branch_tgt;
		end else if (issue) begin
			pc_ff <= PC_W'(pc_ff + 11'h001);
		end else if (bus_wr & (wb_adr_i == PC_OFS)) begin
			pc_ff <= pc_wr;
		end
	end
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			for (int i = 0; i < FILE_DEPTH; i++) begin
				file_mem[i] <= FILE_RST;
			end
		end else if (run & file_we) begin
			file_mem[f_idx] <= alu_res;
		end else if (bus_wr & file_hit) begin
			file_mem[bus_idx] <= byte_wr;
		end
	end
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			exec_ff <= EXEC_RST;
		end else if (issue) begin
			exec_ff <= exec_word;
		end
	end

	// ************************************************************
	// Skip and branch sequencing.
	// ************************************************************
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			skip_ff <= 1'b0;
		end else if (issue) begin
			skip_ff <= ~skip_ff & skip_req;
		end
	end
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_RUN: begin
				if (run & is_branch) begin
					nxt_state = ST_FLUSH;
				end
			end
			ST_FLUSH: begin
				nxt_state = ST_RUN;
			end
			default: begin
				nxt_state = ST_RUN;
			end
		endcase
	end
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			state_ff <= ST_RUN;
			busy_ff <= 1'b0;
		end else if (ce_i) begin
			state_ff <= nxt_state;
			busy_ff <= (nxt_state == ST_FLUSH);
		end
	end

	// ************************************************************
	// Bus answer.
	// ************************************************************
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (wb_adr_i)
			EXEC_OFS: rd_mux = exec_ff;
			ACC_OFS: rd_mux = {24'h00_0000, acc_ff};
			STATUS_OFS: rd_mux = {24'h00_0000, status_ff};
			PC_OFS: rd_mux = {21'h00_0000, pc_ff};
			STATE_OFS: rd_mux = {30'h0000_0000, skip_ff, busy_ff};
			default: rd_mux = file_hit
				? {24'h00_0000, file_mem[bus_idx]} : 32'h0000_0000;
		endcase
	end
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			ack_ff <= 1'b0;
			dat_ff <= 32'h0000_0000;
		end else if (ce_i) begin
			ack_ff <= take;
			if (take & ~wb_we_i) begin
				dat_ff <= rd_mux;
			end
		end
	end
	assign wb_ack_o = ack_ff;
	assign wb_dat_o = dat_ff;
	assign pc_o = pc_ff;
	assign busy_o = busy_ff;
	assign skip_o = skip_ff;

	// ************************************************************
	// Assertions.
	// ************************************************************
	sequence s_branch_issue;
		run && is_branch;
	endsequence
	sequence s_flush_done;
		busy_ff && ce_i;
	endsequence
	a_branch_target: assert property (
		s_branch_issue |=> pc_ff == $past(branch_tgt)
			&& status_ff == $past(status_ff))
		else $error("branch target wrong");
	a_branch_busy: assert property (
		s_branch_issue |=> busy_ff && state_ff == ST_FLUSH)
		else $error("branch did not hold busy");
	a_branch_release: assert property (
		s_branch_issue ##1 s_flush_done |=> !busy_ff)
		else $error("branch lasted over two cycles");
	a_inc_to_acc: assert property (
		run && op == increment_register_op && !dest
		|=> acc_ff == 8'($past(file_rd) + 8'h01)
			&& status_ff[STATUS_Z_BIT] == (acc_ff == 8'h00))
		else $error("increment result or zero wrong");
	a_skip_on_zero: assert property (
		run && op == increment_skip_zero_op
		|=> skip_ff == ($past(file_rd) == 8'hff)
			&& status_ff == $past(status_ff))
		else $error("skip request or flag wrong");
	a_skip_discards: assert property (
		issue && skip_ff |=> !skip_ff && !busy_ff
			&& acc_ff == $past(acc_ff) && status_ff == $past(status_ff)
			&& pc_ff == PC_W'($past(pc_ff) + 11'h001))
		else $error("discarded instruction had effect");
	a_or_immediate: assert property (
		run && op == or_immediate_op
		|=> acc_ff == ($past(acc_ff) | $past(k9[7:0])))
		else $error("or immediate wrong");
	a_or_register_z: assert property (
		run && op == or_accumulator_register_op
		|=> status_ff[STATUS_Z_BIT] == ($past(acc_ff | file_rd) == 8'h00))
		else $error("or register zero flag wrong");
	a_store_no_flag: assert property (
		run && op == store_accumulator_op
		|=> status_ff == $past(status_ff) && acc_ff == $past(acc_ff))
		else $error("store changed flags");
	a_move_to_acc: assert property (
		run && op == move_register_op && !dest
		|=> acc_ff == $past(file_rd))
		else $error("move to accumulator wrong");
	a_move_zero_test: assert property (
		run && op == move_register_op
		|=> status_ff[STATUS_Z_BIT] == ($past(file_rd) == 8'h00))
		else $error("move zero flag wrong");
	a_nop_keeps: assert property (
		run && op == no_operation_op
		|=> acc_ff == $past(acc_ff) && status_ff == $past(status_ff)
			&& pc_ff == PC_W'($past(pc_ff) + 11'h001))
		else $error("no-operation changed state");

endmodule : inc_or_move_branch_exec

// ### tb_inc_or_move_branch_exec.sv
`timescale 1ns/1ps

`define CHK(nm, ex, got) begin \
	checked++; \
	if ((got) !== (ex)) begin \
		mismatches++; \
		$display("mismatch %s exp %h got %h", nm, ex, got); \
	end \
end

module tb_inc_or_move_branch_exec
	import inc_or_move_branch_pkg::*;
();
	// ************************************************************
	// Clock, stimulus and design.
	// ************************************************************
	logic sys_clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic ce_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [ADR_W-1:0] wb_adr_i = '0;
	logic [SEL_W-1:0] wb_sel_i = '0;
	logic [DATA_W-1:0] wb_dat_i = '0;
	logic [DATA_W-1:0] wb_dat_o;
	logic wb_ack_o;
	logic [PC_W-1:0] pc_o;
	logic busy_o;
	logic skip_o;
	int mismatches = 0;
	int checked = 0;
	int cycles = 0;
	logic [PC_W-1:0] pc_exp = '0;
	logic busy_seen;

	always #12.5 sys_clk_i = ~sys_clk_i;

	inc_or_move_branch_exec inc_or_move_branch_exec_inst (
		.sys_clk_i(sys_clk_i), .srst_i(srst_i), .ce_i(ce_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pc_o(pc_o),
		.busy_o(busy_o), .skip_o(skip_o)
	);

	// ************************************************************
	// Bus tasks.
	// ************************************************************
	task automatic give_verdict();
		if (mismatches == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : give_verdict

	task automatic wb(input logic we, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge sys_clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_sel_i <= 4'hf;
		wb_dat_i <= wd;
		do begin
			@(posedge sys_clk_i);
		end while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		busy_seen = busy_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask : wb

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic [31:0] r;
		wb(1'b1, a, v, r);
	endtask : wr

	task automatic chk(input string nm, input logic [7:0] a,
		input logic [31:0] v);
		logic [31:0] r;
		wb(1'b0, a, 32'h0, r);
		`CHK(nm, v, r)
	endtask : chk

	function automatic logic [7:0] fa(input int f);
		return {1'b1, f[4:0], 2'b00};
	endfunction : fa

	// Issues one instruction and checks the counter that follows it.
	task automatic ex(input logic [3:0] op, input logic dst,
		input logic [4:0] f, input logic [8:0] k);
		wr(EXEC_OFS, {7'h00, k, 3'h0, f, 3'h0, dst, op});
		pc_exp = pc_exp + 11'h001;
		`CHK("pc", pc_exp, pc_o)
	endtask : ex

	// ************************************************************
	// Scenarios.
	// ************************************************************
	task automatic t_reset();
		`CHK("pc_rst", 11'h000, pc_o)
		chk("acc_rst", ACC_OFS, 32'h0);
		chk("status_rst", STATUS_OFS, 32'h0);
		chk("state_rst", STATE_OFS, 32'h0);
		chk("file31_rst", fa(31), 32'h0);
		wr(8'h14, 32'hff);
		chk("unmapped", 8'h14, 32'h0);
	endtask : t_reset

	task automatic t_inc();
		wr(fa(5), 32'hff);
		ex(increment_register_op, 1'b0, 5'd5, 9'h0);
		chk("inc_acc", ACC_OFS, 32'h00);
		chk("inc_z", STATUS_OFS, 32'h04);
		chk("inc_f5", fa(5), 32'hff);
		wr(fa(31), 32'h41);
		ex(increment_register_op, 1'b1, 5'd31, 9'h0);
		chk("inc_f31", fa(31), 32'h42);
		chk("inc_acc2", ACC_OFS, 32'h00);
		chk("inc_z2", STATUS_OFS, 32'h00);
	endtask : t_inc

	task automatic t_skip();
		wr(STATUS_OFS, 32'h04);
		wr(fa(4), 32'h10);
		ex(increment_skip_zero_op, 1'b0, 5'd4, 9'h0);
		chk("isz_acc", ACC_OFS, 32'h11);
		chk("isz_keep", STATUS_OFS, 32'h04);
		`CHK("isz_noskip", 1'b0, skip_o)
		wr(fa(3), 32'hff);
		ex(increment_skip_zero_op, 1'b1, 5'd3, 9'h0);
		`CHK("isz_skip", 1'b1, skip_o)
		chk("isz_f3", fa(3), 32'h00);
		chk("isz_z", STATUS_OFS, 32'h04);
		ex(or_immediate_op, 1'b0, 5'd0, 9'h0ff);
		`CHK("skip_clr", 1'b0, skip_o)
		chk("skip_acc", ACC_OFS, 32'h11);
	endtask : t_skip

	task automatic t_branch();
		wr(STATUS_OFS, 32'h44);
		pc_exp = 11'h5ab - 11'h001;
		ex(branch_absolute_op, 1'b0, 5'd0, 9'h1ab);
		`CHK("br_busy", 1'b1, busy_seen)
		chk("br_status", STATUS_OFS, 32'h44);
		`CHK("br_idle", 1'b0, busy_o)
	endtask : t_branch

	task automatic t_or();
		wr(STATUS_OFS, 32'h40);
		wr(ACC_OFS, 32'h00);
		ex(or_immediate_op, 1'b0, 5'd0, 9'h100);
		chk("ori_z", STATUS_OFS, 32'h44);
		wr(ACC_OFS, 32'h81);
		ex(or_immediate_op, 1'b0, 5'd0, 9'h05a);
		chk("ori_acc", ACC_OFS, 32'hdb);
		chk("ori_nz", STATUS_OFS, 32'h40);
		wr(ACC_OFS, 32'h0f);
		wr(fa(7), 32'hf0);
		ex(or_accumulator_register_op, 1'b1, 5'd7, 9'h0);
		chk("orr_f7", fa(7), 32'hff);
		chk("orr_acc", ACC_OFS, 32'h0f);
		wr(ACC_OFS, 32'h00);
		ex(or_accumulator_register_op, 1'b0, 5'd8, 9'h0);
		chk("orr_z", STATUS_OFS, 32'h44);
	endtask : t_or

	task automatic t_move();
		wr(ACC_OFS, 32'h3c);
		ex(store_accumulator_op, 1'b1, 5'd9, 9'h0);
		chk("st_f9", fa(9), 32'h3c);
		chk("st_flags", STATUS_OFS, 32'h44);
		wr(fa(11), 32'h77);
		ex(move_register_op, 1'b0, 5'd11, 9'h0);
		chk("mv_acc", ACC_OFS, 32'h77);
		chk("mv_nz", STATUS_OFS, 32'h40);
		ex(move_register_op, 1'b1, 5'd10, 9'h0);
		chk("mv_f10", fa(10), 32'h00);
		chk("mv_z", STATUS_OFS, 32'h44);
	endtask : t_move

	task automatic t_nop();
		for (int i = 0; i < 9; i++) begin
			ex((i == 0) ? 4'h0 : 4'(i + 7), 1'b1, 5'd11, 9'h1ff);
		end
		chk("nop_acc", ACC_OFS, 32'h77);
		chk("nop_status", STATUS_OFS, 32'h44);
		chk("nop_f11", fa(11), 32'h77);
	endtask : t_nop

	// Clock enable low holds off the answer and the counter.
	task automatic t_freeze();
		@(posedge sys_clk_i);
		ce_i <= 1'b0;
		fork
			ex(no_operation_op, 1'b0, 5'd0, 9'h0);
			begin
				repeat (4) @(posedge sys_clk_i);
				`CHK("ce_ack", 1'b0, wb_ack_o)
				`CHK("ce_pc", pc_exp, pc_o)
				ce_i <= 1'b1;
			end
		join
	endtask : t_freeze

	// ************************************************************
	// Sequence and timeout.
	// ************************************************************
	always @(posedge sys_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			mismatches++;
			give_verdict();
		end
	end

	initial begin
		repeat (4) @(posedge sys_clk_i);
		srst_i <= 1'b0;
		@(posedge sys_clk_i);
		t_reset();
		t_inc();
		t_skip();
		t_branch();
		t_or();
		t_move();
		t_nop();
		t_freeze();
		give_verdict();
	end
endmodule : tb_inc_or_move_branch_exec
